/* sdm_pkg.sv */
/*
  Shared constants and carrier types for the modulator mode and link block.
  Assumes a single 20 MHz core clock and a 32-bit AHB-Lite register bus.
*/
package sdm_pkg;

  localparam int GAIN_W = 5;
  localparam int RATE_W = 3;
  localparam int CFG_W = 8;
  localparam int ST_W = 3;
  localparam int PIN_W = 14;

  // Core clock period in ns; the modulator clock is the core clock over four.
  localparam int CORE_CLK_NS = 50;
  localparam int MCLK_DIV = 4;
  localparam logic [1:0] DIV_STEP = 2'h1;
  localparam logic [1:0] MCLK_HIGH_END = 2'(MCLK_DIV / 2);
  localparam logic [1:0] DIV_LAST = 2'(MCLK_DIV - 1);
  localparam logic [1:0] SAMPLE_PHASE = 2'h2;

  // Register byte offsets.
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0C;
  localparam logic [7:0] OFS_ONES = 8'h10;

  // Field positions.
  localparam int ST_OVR = 0;
  localparam int ST_WRDONE = 1;
  localparam int ST_FRERR = 2;
  localparam int CTRL_PWRDN = 0;
  localparam int CFG_HW_BIT = 8;
  localparam int CFG_LINES_LSB = 16;
  localparam int CFG_RATE_LSB = 24;

  // Reset values and counts.
  localparam logic [ST_W-1:0] STATUS_RST = 3'h0;
  localparam logic [ST_W-1:0] MASK_RST = 3'h0;
  localparam logic CTRL_PWRDN_RST = 1'b0;
  localparam logic [3:0] SER_BITS = 4'h8;
  localparam logic [3:0] SER_CNT_MAX = 4'hF;
  localparam logic [15:0] ONES_STEP = 16'h0001;

  typedef logic [31:0][GAIN_W-1:0] sdm_gain_lut_type;
  typedef logic [7:0][RATE_W-1:0] sdm_rate_lut_type;

  typedef struct packed {
    logic [GAIN_W-1:0] gainMux;
    logic [RATE_W-1:0] rate;
    logic hwSel;
    logic sclk;
    logic csN;
    logic din;
    logic bitstream;
    logic overrange;
  } sdm_pins_type;

  typedef struct packed {
    logic [GAIN_W-1:0] gainMux;
    logic [RATE_W-1:0] rate;
  } sdm_cfg_type;

  typedef struct packed {
    sdm_cfg_type cfg;
    logic [GAIN_W-1:0] ctrlLines;
    logic [RATE_W-1:0] rateCode;
    logic [1:0] divCnt;
    logic mclk;
    logic bitOut;
    logic bitValid;
    logic [15:0] onesCnt;
    logic prevSclk;
    logic prevCsN;
    logic prevOvr;
    logic [CFG_W-1:0] inShift;
    logic [3:0] bitCnt;
    logic [CFG_W-1:0] outShift;
    logic dout;
    logic doutOe;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic pwrDn;
    logic irq;
    logic dphWrite;
    logic [7:0] dphAddr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } sdm_state_type;

  function automatic sdm_gain_lut_type sdm_gain_ident();
    sdm_gain_lut_type t;
    for (int i = 0; i < 32; i++) begin
      t[i] = 5'(i);
    end
    return t;
  endfunction

  function automatic sdm_rate_lut_type sdm_rate_ident();
    sdm_rate_lut_type t;
    for (int i = 0; i < 8; i++) begin
      t[i] = 3'(i);
    end
    return t;
  endfunction

endpackage

/* sdm_pin_sync.sv */
/*
  Two-stage synchroniser for every pin that enters the core clock domain.
  Assumes the pins are asynchronous levels; only the second stage is used.
*/
`timescale 1ns/100ps
module sdm_pin_sync
  import sdm_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Raw and synchronised pins
  input wire logic [PIN_W-1:0] pinsRaw,
  output logic [PIN_W-1:0] pinsSync
);

  logic [PIN_W-1:0] meta_ff;
  logic [PIN_W-1:0] sync_ff;

  genvar g;
  generate
    for (g = 0; g < PIN_W; g++) begin : gBit
      always_ff @(posedge core_clk) begin
        meta_ff[g] <= pinsRaw[g];
        sync_ff[g] <= meta_ff[g];
      end
    end
  endgenerate

  assign pinsSync = sync_ff;

endmodule

/* sdm_mode_link.sv */
/*
  Mode configuration and modulator link logic on the decimation filter side:
  pin or serial selection of the gain/mux and rate codes, the five modulator
  control lines, the divided modulator clock, bitstream and overrange capture,
  and an AHB-Lite register slave with a level interrupt.
  Assumes all pins are asynchronous and one AHB-Lite master with no waits.
*/
// Our own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/100ps
module sdm_mode_link
  import sdm_pkg::*;
#(
  parameter sdm_gain_lut_type GAIN_LUT = sdm_gain_ident(),
  parameter sdm_rate_lut_type RATE_LUT = sdm_rate_ident()
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Hardware selection pins
  input wire logic [GAIN_W-1:0] gainMuxSelectPins,
  input wire logic [RATE_W-1:0] rateSelectPins,
  input wire logic hwSwSelect,
  // Serial port
  input wire logic serialClk,
  input wire logic chipSelectN,
  input wire logic serialDin,
  output logic serialDout,
  output logic serialDoutOe,
  // Modulator link
  output logic [GAIN_W-1:0] modulatorCtrlLines,
  output logic modulatorClk,
  input wire logic modulatorBitstream,
  input wire logic overrangePulse,
  // Filter side
  output logic [RATE_W-1:0] decimRateCode,
  output logic filterBit,
  output logic filterBitValid,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Interrupt
  output logic irq
);

  sdm_state_type st_ff;
  sdm_state_type nxt_st;
  sdm_pins_type pinS;
  logic [PIN_W-1:0] pinsSyncBits;
  logic sclkFall;
  logic sclkRise;
  logic csFall;
  logic csRise;
  logic commit;
  logic ovrRise;
  logic addrPhase;

  sdm_pin_sync u_sync (
    .core_clk(core_clk),
    .pinsRaw({gainMuxSelectPins, rateSelectPins, hwSwSelect, serialClk,
              chipSelectN, serialDin, modulatorBitstream, overrangePulse}),
    .pinsSync(pinsSyncBits)
  );

  assign pinS = sdm_pins_type'(pinsSyncBits);

  assign sclkFall = st_ff.prevSclk && !pinS.sclk;
  assign sclkRise = !st_ff.prevSclk && pinS.sclk;
  assign csFall = st_ff.prevCsN && !pinS.csN;
  assign csRise = !st_ff.prevCsN && pinS.csN;
  assign commit = csRise && (st_ff.bitCnt == SER_BITS) && !pinS.hwSel;
  assign ovrRise = pinS.overrange && !st_ff.prevOvr;
  assign addrPhase = hsel && htrans[1] && hready;

  always_comb begin
    logic [ST_W-1:0] events;
    logic [ST_W-1:0] w1c;
    logic [31:0] rdVal;
    logic onesClr;
    events = '0;
    w1c = '0;
    rdVal = '0;
    onesClr = 1'b0;
    nxt_st = st_ff;
    nxt_st.prevSclk = pinS.sclk;
    nxt_st.prevCsN = pinS.csN;
    nxt_st.prevOvr = pinS.overrange;

    if (st_ff.pwrDn) begin
      nxt_st.divCnt = DIV_LAST;
      nxt_st.mclk = 1'b0;
    end else begin
      nxt_st.divCnt = st_ff.divCnt + DIV_STEP;
      nxt_st.mclk = (nxt_st.divCnt < MCLK_HIGH_END);
    end

    nxt_st.bitValid = !st_ff.pwrDn && (st_ff.divCnt == SAMPLE_PHASE);
    if (nxt_st.bitValid) begin
      nxt_st.bitOut = pinS.bitstream;
    end

    events[ST_OVR] = ovrRise;

    if (csFall) begin
      nxt_st.bitCnt = '0;
      nxt_st.outShift = st_ff.cfg;
    end else if (!pinS.csN) begin
      if (sclkFall) begin
        nxt_st.inShift = {st_ff.inShift[CFG_W-2:0], pinS.din};
        if (st_ff.bitCnt != SER_CNT_MAX) begin
          nxt_st.bitCnt = st_ff.bitCnt + 4'h1;
        end
      end
      if (sclkRise) begin
        nxt_st.outShift = {st_ff.outShift[CFG_W-2:0], 1'b0};
      end
    end
    nxt_st.dout = nxt_st.outShift[CFG_W-1];
    nxt_st.doutOe = !pinS.csN;

    if (pinS.hwSel) begin
      nxt_st.cfg.gainMux = pinS.gainMux;
      nxt_st.cfg.rate = pinS.rate;
    end else if (commit) begin
      nxt_st.cfg = sdm_cfg_type'(st_ff.inShift);
    end
    events[ST_WRDONE] = commit;
    events[ST_FRERR] = csRise && !pinS.hwSel && (st_ff.bitCnt != SER_BITS)
                       && (st_ff.bitCnt != 4'h0);

    nxt_st.ctrlLines = GAIN_LUT[st_ff.cfg.gainMux];
    nxt_st.rateCode = RATE_LUT[st_ff.cfg.rate];

    // Register write in the data phase.
    if (st_ff.dphWrite) begin
      case (st_ff.dphAddr)
        OFS_STATUS: begin
          w1c = hwdata[ST_W-1:0];
        end
        OFS_MASK: begin
          nxt_st.mask = hwdata[ST_W-1:0];
        end
        OFS_CTRL: begin
          nxt_st.pwrDn = hwdata[CTRL_PWRDN];
        end
        OFS_ONES: begin
          onesClr = 1'b1;
        end
        default: w1c = '0;
      endcase
    end

    if (onesClr) begin
      nxt_st.onesCnt = '0;
    end else if (nxt_st.bitValid && pinS.bitstream) begin
      nxt_st.onesCnt = st_ff.onesCnt + ONES_STEP;
    end

    // A new event beats a clear in the same cycle.
    nxt_st.status = (st_ff.status & ~w1c) | events;
    nxt_st.irq = |(st_ff.status & st_ff.mask);

    // Read data is fetched in the address phase so the slave never waits.
    case (haddr[7:0])
      OFS_CONFIG: begin
        rdVal[CFG_W-1:0] = st_ff.cfg;
        rdVal[CFG_HW_BIT] = pinS.hwSel;
        rdVal[CFG_LINES_LSB +: GAIN_W] = st_ff.ctrlLines;
        rdVal[CFG_RATE_LSB +: RATE_W] = st_ff.rateCode;
      end
      OFS_STATUS: begin
        rdVal[ST_W-1:0] = st_ff.status;
      end
      OFS_MASK: begin
        rdVal[ST_W-1:0] = st_ff.mask;
      end
      OFS_CTRL: begin
        rdVal[CTRL_PWRDN] = st_ff.pwrDn;
      end
      OFS_ONES: begin
        rdVal[15:0] = st_ff.onesCnt;
      end
      default: rdVal = '0;
    endcase
    nxt_st.dphWrite = addrPhase && hwrite;
    if (addrPhase) begin
      nxt_st.dphAddr = haddr[7:0];
      if (!hwrite) begin
        nxt_st.hrdata = rdVal;
      end
    end
    nxt_st.hreadyout = 1'b1;
    nxt_st.hresp = 1'b0;

    if (srst) begin
      nxt_st = '0;
      nxt_st.cfg.gainMux = pinS.gainMux;
      nxt_st.cfg.rate = pinS.rate;
      nxt_st.ctrlLines = GAIN_LUT[pinS.gainMux];
      nxt_st.rateCode = RATE_LUT[pinS.rate];
      nxt_st.divCnt = DIV_LAST;
      nxt_st.prevSclk = pinS.sclk;
      nxt_st.prevCsN = 1'b1;
      nxt_st.prevOvr = pinS.overrange;
      nxt_st.status = STATUS_RST;
      nxt_st.mask = MASK_RST;
      nxt_st.pwrDn = CTRL_PWRDN_RST;
      nxt_st.hreadyout = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    st_ff <= nxt_st;
  end

  assign serialDout = st_ff.dout;
  assign serialDoutOe = st_ff.doutOe;
  assign modulatorCtrlLines = st_ff.ctrlLines;
  assign modulatorClk = st_ff.mclk;
  assign decimRateCode = st_ff.rateCode;
  assign filterBit = st_ff.bitOut;
  assign filterBitValid = st_ff.bitValid;
  assign hreadyout = st_ff.hreadyout;
  assign hresp = st_ff.hresp;
  assign hrdata = st_ff.hrdata;
  assign irq = st_ff.irq;

  sequence s_mclk_tail;
    st_ff.mclk ##1 !st_ff.mclk;
  endsequence

  sequence s_mclk_start;
    $rose(st_ff.mclk) && !st_ff.pwrDn ##1 !st_ff.pwrDn;
  endsequence

  property p_mclk_div;
    @(posedge core_clk) disable iff (srst)
      $rose(st_ff.mclk) && !st_ff.pwrDn |=> s_mclk_tail;
  endproperty
  a_mclk_div: assert property (p_mclk_div)
    else $error("Modulator clock high phase is not two cycles.");

  property p_mclk_period;
    @(posedge core_clk) disable iff (srst)
      s_mclk_start ##1 !st_ff.pwrDn ##1 !st_ff.pwrDn |=> $rose(st_ff.mclk);
  endproperty
  a_mclk_period: assert property (p_mclk_period)
    else $error("Modulator clock period is not four cycles.");

  property p_pwrdn_static;
    @(posedge core_clk) disable iff (srst)
      st_ff.pwrDn |=> !st_ff.mclk && !st_ff.bitValid;
  endproperty
  a_pwrdn_static: assert property (p_pwrdn_static)
    else $error("Modulator clock runs during power-down.");

  property p_hw_copy;
    @(posedge core_clk) disable iff (srst)
      pinS.hwSel |=> st_ff.cfg.gainMux == $past(pinS.gainMux)
                     && st_ff.cfg.rate == $past(pinS.rate);
  endproperty
  a_hw_copy: assert property (p_hw_copy)
    else $error("Hardware mode config does not follow the pins.");

  property p_lines_map;
    @(posedge core_clk) disable iff (srst)
      ##1 st_ff.ctrlLines == GAIN_LUT[$past(st_ff.cfg.gainMux)];
  endproperty
  a_lines_map: assert property (p_lines_map)
    else $error("Control lines disagree with the gain lookup.");

  property p_rate_map;
    @(posedge core_clk) disable iff (srst)
      ##1 st_ff.rateCode == RATE_LUT[$past(st_ff.cfg.rate)];
  endproperty
  a_rate_map: assert property (p_rate_map)
    else $error("Rate code disagrees with the rate lookup.");

  property p_sw_hold;
    @(posedge core_clk) disable iff (srst)
      !pinS.hwSel && !commit |=> $stable(st_ff.cfg);
  endproperty
  a_sw_hold: assert property (p_sw_hold)
    else $error("Config changed without a completed write.");

  property p_sw_commit;
    @(posedge core_clk) disable iff (srst)
      commit |=> st_ff.cfg == $past(st_ff.inShift) ##1
                 st_ff.ctrlLines == GAIN_LUT[st_ff.cfg.gainMux];
  endproperty
  a_sw_commit: assert property (p_sw_commit)
    else $error("Completed serial write did not reach the lines.");

  property p_ovr_sticky;
    @(posedge core_clk) disable iff (srst)
      ovrRise |=> st_ff.status[ST_OVR] ##1 st_ff.irq == st_ff.mask[ST_OVR]
                  || $past(st_ff.status) != 3'h1;
  endproperty
  a_ovr_sticky: assert property (p_ovr_sticky)
    else $error("Overrange pulse was not captured.");

  property p_sample_phase;
    @(posedge core_clk) disable iff (srst)
      st_ff.bitValid |-> $past(st_ff.divCnt) == SAMPLE_PHASE ##1
                         !st_ff.bitValid [*3];
  endproperty
  a_sample_phase: assert property (p_sample_phase)
    else $error("Bitstream sampled outside its window.");

  property p_cs_hiz;
    @(posedge core_clk) disable iff (srst)
      pinS.csN |=> !st_ff.doutOe;
  endproperty
  a_cs_hiz: assert property (p_cs_hiz)
    else $error("Serial output driven while deselected.");

  property p_reset_load;
    @(posedge core_clk)
      srst && $past(srst, 2) |=> st_ff.cfg.gainMux == $past(pinS.gainMux)
               && st_ff.status == STATUS_RST;
  endproperty
  a_reset_load: assert property (p_reset_load)
    else $error("Reset did not load pins or clear status.");

endmodule

/* sdm_modulator_model.sv */
/*
  Behavioural model of the sigma-delta modulator on the far side of the link.
  Assumes it is fed the block's control lines and modulator clock directly.
*/
`timescale 1ns/100ps
module sdm_modulator_model
  import sdm_pkg::*;
(
  // Clocks
  input wire logic core_clk,
  input wire logic modulatorClk,
  // Control lines, wired straight across
  input wire logic [GAIN_W-1:0] modulatorCtrlLines,
  // Stimulus from the bench
  input wire logic onesEn,
  input wire logic ovrReq,
  // Modulator outputs
  output logic modulatorBitstream,
  output logic overrangePulse,
  output logic [2:0] gainSel,
  output logic [1:0] muxSel,
  output logic asleep
);
  logic bitHeld = 1'b0;
  logic prevClk = 1'b0;
  int idle = 0;
  initial overrangePulse = 1'b0;
  assign gainSel = modulatorCtrlLines[2:0];
  assign muxSel = modulatorCtrlLines[4:3];
  assign asleep = idle >= 8;
  always @(posedge core_clk) begin
    prevClk <= modulatorClk;
    idle <= (modulatorClk != prevClk) ? 0 : idle + 1;
  end
  always @(posedge modulatorClk) begin
    bitHeld <= onesEn & !asleep;
    overrangePulse <= ovrReq;
  end
  // The bit is only valid in the high half, so it returns to zero each period.
  assign modulatorBitstream = bitHeld & modulatorClk;
endmodule

/* sdm_mode_link_tb.sv */
/*
  Self-checking bench for the modulator mode and link block.
  Assumes the default identity code tables and a 20 MHz core clock.
*/
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module sdm_mode_link_tb
  import sdm_pkg::*;
;
  logic core_clk = 1'b0, srst = 1'b1, hwSwSelect = 1'b1;
  logic [4:0] gainMuxSelectPins = 5'h0B;
  logic [2:0] rateSelectPins = 3'h6;
  logic serialClk = 1'b1, chipSelectN = 1'b1, serialDin = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0, onesEn = 1'b0, ovrReq = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic serialDout, serialDoutOe, modulatorClk, modulatorBitstream;
  logic overrangePulse, filterBit, filterBitValid, hreadyout, hresp, irq;
  logic asleep, prevM = 1'b0;
  logic [4:0] modulatorCtrlLines;
  logic [2:0] decimRateCode, gainSel;
  logic [1:0] muxSel;
  logic [31:0] hrdata, rd;
  logic [7:0] sb;
  int failures = 0, n_checks = 0, mRise = 0, mHigh = 0, vCnt = 0, r0;
  always #25 core_clk = ~core_clk;
  sdm_mode_link uut (.core_clk(core_clk), .srst(srst),
    .gainMuxSelectPins(gainMuxSelectPins), .rateSelectPins(rateSelectPins),
    .hwSwSelect(hwSwSelect), .serialClk(serialClk),
    .chipSelectN(chipSelectN), .serialDin(serialDin),
    .serialDout(serialDout), .serialDoutOe(serialDoutOe),
    .modulatorCtrlLines(modulatorCtrlLines), .modulatorClk(modulatorClk),
    .modulatorBitstream(modulatorBitstream),
    .overrangePulse(overrangePulse), .decimRateCode(decimRateCode),
    .filterBit(filterBit), .filterBitValid(filterBitValid), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .irq(irq));
  sdm_modulator_model mdl (.core_clk(core_clk), .modulatorClk(modulatorClk),
    .modulatorCtrlLines(modulatorCtrlLines), .onesEn(onesEn),
    .ovrReq(ovrReq), .modulatorBitstream(modulatorBitstream),
    .overrangePulse(overrangePulse), .gainSel(gainSel), .muxSel(muxSel),
    .asleep(asleep));
  // Counted on the falling edge, so that tasks acting on the rising edge
  // can zero and read these counters without a race.
  always @(negedge core_clk) begin
    prevM <= modulatorClk;
    if (modulatorClk === 1'b1 && prevM === 1'b0) mRise++;
    if (modulatorClk === 1'b1) mHigh++;
    if (filterBitValid === 1'b1) vCnt++;
  end
  function automatic logic [31:0] cfgw(logic [4:0] g, logic [2:0] r,
                                       logic h);
    return {5'h0, r, 3'h0, g, 7'h0, h, g, r};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask
  task automatic ser(input logic [7:0] b, input int n);
    sb = 8'h00;
    chipSelectN <= 1'b0;
    cyc(6);
    `CHK("doutOe", 1'b1, serialDoutOe)
    for (int i = 0; i < n; i++) begin
      sb[7-i] = serialDout;
      serialDin <= b[7-i];
      cyc(4);
      serialClk <= 1'b0;
      cyc(4);
      serialClk <= 1'b1;
      cyc(4);
    end
    chipSelectN <= 1'b1;
    cyc(8);
    `CHK("doutOff", 1'b0, serialDoutOe)
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic t_reset();
    ahb(1'b0, OFS_CONFIG, 32'h0);
    `CHK("config", cfgw(5'h0B, 3'h6, 1'b1), rd)
    ahb(1'b0, OFS_STATUS, 32'h0);
    `CHK("status", 32'h0, rd)
    `CHK("gain", 3'h3, gainSel)
    `CHK("mux", 2'h1, muxSel)
    $display("reset test done");
  endtask
  task automatic t_hw();
    gainMuxSelectPins <= 5'h1C;
    rateSelectPins <= 3'h3;
    cyc(8);
    `CHK("lines", 5'h1C, modulatorCtrlLines)
    `CHK("rate", 3'h3, decimRateCode)
    ser(8'hFF, 8);
    `CHK("readback", 8'hE3, sb)
    `CHK("linesKeep", 5'h1C, modulatorCtrlLines)
    ahb(1'b0, OFS_STATUS, 32'h0);
    `CHK("noCommit", 32'h0, rd)
    $display("hardware mode test done");
  endtask
  task automatic t_sw();
    hwSwSelect <= 1'b0;
    cyc(6);
    ser(8'h5A, 8);
    `CHK("oldCfg", 8'hE3, sb)
    `CHK("swLines", 5'h0B, modulatorCtrlLines)
    `CHK("swRate", 3'h2, decimRateCode)
    gainMuxSelectPins <= 5'h07;
    ser(8'h00, 7);
    `CHK("partial", 5'h0B, modulatorCtrlLines)
    ahb(1'b0, OFS_STATUS, 32'h0);
    `CHK("stWrite", 32'h6, rd)
    ahb(1'b1, OFS_STATUS, 32'h6);
    ahb(1'b0, OFS_STATUS, 32'h0);
    `CHK("stClr", 32'h0, rd)
    $display("software mode test done");
  endtask
  task automatic t_clk();
    r0 = mRise;
    mHigh = 0;
    vCnt = 0;
    cyc(80);
    `CHK("mclkRise", 20, mRise - r0)
    `CHK("mclkHigh", 40, mHigh)
    `CHK("valid", 20, vCnt)
    ahb(1'b1, OFS_CTRL, 32'h1);
    cyc(4);
    r0 = mRise;
    cyc(40);
    `CHK("pdRise", 0, mRise - r0)
    `CHK("asleep", 1'b1, asleep)
    ahb(1'b1, OFS_CTRL, 32'h0);
    cyc(20);
    `CHK("awake", 1'b0, asleep)
    $display("clock test done");
  endtask
  task automatic t_ovr();
    ovrReq <= 1'b1;
    cyc(8);
    ovrReq <= 1'b0;
    cyc(12);
    ahb(1'b0, OFS_STATUS, 32'h0);
    `CHK("ovrSt", 32'h1, rd)
    `CHK("irqMasked", 1'b0, irq)
    ahb(1'b1, OFS_MASK, 32'h1);
    cyc(3);
    `CHK("irqOn", 1'b1, irq)
    ahb(1'b1, OFS_STATUS, 32'h1);
    cyc(3);
    `CHK("irqOff", 1'b0, irq)
    $display("overrange test done");
  endtask
  task automatic t_ones();
    ahb(1'b1, OFS_ONES, 32'h0);
    onesEn <= 1'b1;
    cyc(80);
    `CHK("filterBit1", 1'b1, filterBit)
    onesEn <= 1'b0;
    cyc(12);
    `CHK("filterBit0", 1'b0, filterBit)
    ahb(1'b0, OFS_ONES, 32'h0);
    `CHK("ones", 1'b1, rd >= 19 && rd <= 21)
    ahb(1'b1, 8'h20, 32'hFFFF_FFFF);
    ahb(1'b0, 8'h20, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    $display("bitstream test done");
  endtask
  initial begin
    cyc(16);
    srst <= 1'b0;
    cyc(2);
    t_reset();
    t_hw();
    t_sw();
    t_clk();
    t_ovr();
    t_ones();
    finish_test();
  end
  // The longest sequence runs well under 3000 cycles.
  initial begin
    cyc(20000);
    failures++;
    $display("[FAIL] watchdog expired");
    finish_test();
  end
endmodule
